// ===== bdb_pkg.sv
// Constants for the byte decrement and branch execution unit.
// Assumes an 8-bit CPU with 16-bit data addresses and a 9-bit data path.
package bdb_pkg;

   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_SHORT_PAGE0  = 8'h34;
   localparam logic [7:0] OP_SHORT_PAGE1  = 8'h35;
   localparam logic [7:0] OP_SHORT_PAGEFE = 8'h33;
   localparam logic [7:0] OP_LONG         = 8'h36;
   localparam logic [7:0] OP_INDIRECT     = 8'h9A;

   // ------------------------------------------------------------
   // Address pages reached by the short forms
   // ------------------------------------------------------------
   localparam logic [7:0] PAGE0_HI  = 8'h00;
   localparam logic [7:0] PAGE1_HI  = 8'h01;
   localparam logic [7:0] PAGEFE_HI = 8'hFE;

   // ------------------------------------------------------------
   // Byte and cycle counts
   // ------------------------------------------------------------
   localparam logic [2:0] LEN_SHORT = 3'h3;
   localparam logic [2:0] LEN_LONG  = 3'h4;
   localparam logic [2:0] LEN_IND   = 3'h2;
   localparam logic [1:0] CYC_SHORT = 2'h2;
   localparam logic [1:0] CYC_LONG  = 2'h3;
   localparam logic [1:0] CYC_IND   = 2'h2;

   // ------------------------------------------------------------
   // Field layout and data constants
   // ------------------------------------------------------------
   localparam int         IDX_SEL_BIT   = 0;
   localparam int         IDX_LSB       = 1;
   localparam int         IDX_MSB       = 6;
   localparam int         IDX_RSVD_BIT  = 7;
   localparam int         BIT8_POS      = 8;
   localparam int         PSW_NINTH_POS = 1;
   localparam logic       BIT8_ASSUMED  = 1'b1;
   localparam logic [8:0] DEC_ONE       = 9'h001;
   localparam logic [7:0] BYTE_ZERO     = 8'h00;
   localparam logic [7:0] PSW_MASK      = 8'h02;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PTR_LO,
      ST_PTR_HI,
      ST_RD,
      ST_WR
   } bdb_state_t;

endpackage : bdb_pkg

// ===== bdb_exec.sv
// Execution unit for byte decrement, decrement-and-branch-if-zero and
// indirect byte decrement instructions.
// Assumes the decoder hands over all instruction bytes with START_I, and
// that the data bus answers every read or write strobe with MEM_ACK_I.
`timescale 1ns/10ps
`default_nettype none

module bdb_exec
   import bdb_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        RESET_I,
   input  wire logic        START_I,
   input  wire logic [7:0]  OPCODE_I,
   input  wire logic [7:0]  OPND1_I,
   input  wire logic [7:0]  OPND2_I,
   input  wire logic [7:0]  OPND3_I,
   input  wire logic [15:0] PC_I,
   input  wire logic [7:0]  DISP_I,
   input  wire logic [8:0]  MEM_RDATA_I,
   input  wire logic        MEM_HAS_B8_I,
   input  wire logic        MEM_ACK_I,
   output logic             BUSY_O,
   output logic             DONE_O,
   output logic             ILLEGAL_O,
   output logic [15:0]      PC_O,
   output logic [2:0]       LEN_O,
   output logic [1:0]       CYCLES_O,
   output logic [15:0]      MEM_ADDR_O,
   output logic             MEM_RD_O,
   output logic             MEM_WR_O,
   output logic [8:0]       MEM_WDATA_O,
   output logic             PSW_WE_O,
   output logic [7:0]       PSW_MASK_O,
   output logic [7:0]       PSW_WDATA_O
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] sext8(input logic [7:0] b);
      sext8 = {{8{b[7]}}, b};
   endfunction : sext8

   function automatic logic [15:0] short_addr(input logic [7:0] hi,
                                              input logic [7:0] lo);
      short_addr = {hi, lo};
   endfunction : short_addr

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   bdb_state_t  st;
   bdb_state_t  next_st;
   logic [15:0] pc;
   logic [15:0] next_pc;
   logic [7:0]  rel;
   logic [7:0]  next_rel;
   logic [7:0]  disp;
   logic [7:0]  next_disp;
   logic [7:0]  ptr_lo;
   logic [7:0]  next_ptr_lo;
   logic        branch;
   logic        next_branch;
   logic        indexed;
   logic        next_indexed;
   logic        busy;
   logic        next_busy;
   logic        done;
   logic        next_done;
   logic        illegal;
   logic        next_illegal;
   logic [15:0] pc_out;
   logic [15:0] next_pc_out;
   logic [2:0]  len;
   logic [2:0]  next_len;
   logic [1:0]  cyc;
   logic [1:0]  next_cyc;
   logic [15:0] addr;
   logic [15:0] next_addr;
   logic        rd;
   logic        next_rd;
   logic        wr;
   logic        next_wr;
   logic [8:0]  wdata;
   logic [8:0]  next_wdata;
   logic        psw_we;
   logic        next_psw_we;
   logic [7:0]  psw_data;
   logic [7:0]  next_psw_data;
   // Mask is a constant, but is registered so every output leaves a flop
   logic [7:0]  psw_mask;
   logic [7:0]  next_psw_mask;

   // Result of the nine-bit decrement, valid while a read is acknowledged
   logic [8:0]  operand9;
   logic [8:0]  result9;
   logic        is_zero;
   logic [15:0] pc_seq;

   always_comb
   begin
      // Missing bit 8 is taken as one before decrementing
      operand9 = MEM_HAS_B8_I ? MEM_RDATA_I
                              : {BIT8_ASSUMED, MEM_RDATA_I[7:0]};
      // 100H - 1 = 0FFH with bit 8 clear: a clear flag marks the borrow
      result9  = operand9 - DEC_ONE;
      is_zero  = (wdata[7:0] == BYTE_ZERO);
      pc_seq   = pc + {13'h0000, len};
   end

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      next_st       = st;
      next_pc       = pc;
      next_rel      = rel;
      next_disp     = disp;
      next_ptr_lo   = ptr_lo;
      next_branch   = branch;
      next_indexed  = indexed;
      next_pc_out   = pc_out;
      next_len      = len;
      next_cyc      = cyc;
      next_addr     = addr;
      next_rd       = rd;
      next_wr       = wr;
      next_wdata    = wdata;
      next_psw_data = psw_data;
      next_psw_mask = PSW_MASK;
      next_done     = 1'b0;
      next_illegal  = 1'b0;
      next_psw_we   = 1'b0;
      unique case (st)
         ST_IDLE:
         begin
            if (START_I)
            begin
               next_pc      = PC_I;
               next_disp    = DISP_I;
               next_branch  = 1'b1;
               next_indexed = 1'b0;
               next_rd      = 1'b1;
               next_st      = ST_RD;
               next_rel     = OPND2_I;
               next_len     = LEN_SHORT;
               next_cyc     = CYC_SHORT;
               case (OPCODE_I)
                  OP_SHORT_PAGE0:
                     next_addr = short_addr(PAGE0_HI, OPND1_I);
                  OP_SHORT_PAGE1:
                     next_addr = short_addr(PAGE1_HI, OPND1_I);
                  OP_SHORT_PAGEFE:
                     next_addr = short_addr(PAGEFE_HI, OPND1_I);
                  OP_LONG:
                  begin
                     next_addr = {OPND2_I, OPND1_I};
                     next_rel  = OPND3_I;
                     next_len  = LEN_LONG;
                     next_cyc  = CYC_LONG;
                  end
                  OP_INDIRECT:
                  begin
                     next_branch  = 1'b0;
                     next_len     = LEN_IND;
                     next_cyc     = CYC_IND;
                     next_indexed = OPND1_I[IDX_SEL_BIT];
                     // Byte address of the pointer is twice its index
                     next_addr    = {9'h000,
                                     OPND1_I[IDX_MSB:IDX_LSB],
                                     1'b0};
                     next_st      = ST_PTR_LO;
                     // Index fills six bits, so 0..63 all decode
                     if (OPND1_I[IDX_RSVD_BIT])
                     begin
                        next_rd      = 1'b0;
                        next_illegal = 1'b1;
                        next_st      = ST_IDLE;
                     end
                  end
                  default:
                  begin
                     next_rd      = 1'b0;
                     next_illegal = 1'b1;
                     next_st      = ST_IDLE;
                  end
               endcase
            end
         end
         ST_PTR_LO:
         begin
            if (MEM_ACK_I)
            begin
               next_ptr_lo = MEM_RDATA_I[7:0];
               next_addr   = addr + 16'h0001;
               next_st     = ST_PTR_HI;
            end
         end
         ST_PTR_HI:
         begin
            if (MEM_ACK_I)
            begin
               // Wraps at 64K; the displacement is sign extended
               next_addr = {MEM_RDATA_I[7:0], ptr_lo}
                         + (indexed ? sext8(disp)
                                    : 16'h0000);
               next_st   = ST_RD;
            end
         end
         ST_RD:
         begin
            if (MEM_ACK_I)
            begin
               next_rd    = 1'b0;
               next_wr    = 1'b1;
               next_wdata = result9;
               next_st    = ST_WR;
            end
         end
         ST_WR:
         begin
            if (MEM_ACK_I)
            begin
               next_wr       = 1'b0;
               next_done     = 1'b1;
               next_psw_we   = 1'b1;
               next_psw_data = {6'h00, wdata[BIT8_POS], 1'b0};
               next_st       = ST_IDLE;
               // Offset applies only to branch forms with a zero byte
               if (branch && is_zero)
                  next_pc_out = pc_seq + sext8(rel);
               else
                  next_pc_out = pc_seq;
            end
         end
      endcase
      next_busy = (next_st != ST_IDLE);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         st       <= ST_IDLE;
         pc       <= 16'h0000;
         rel      <= 8'h00;
         disp     <= 8'h00;
         ptr_lo   <= 8'h00;
         branch   <= 1'b0;
         indexed  <= 1'b0;
         busy     <= 1'b0;
         done     <= 1'b0;
         illegal  <= 1'b0;
         pc_out   <= 16'h0000;
         len      <= 3'h0;
         cyc      <= 2'h0;
         addr     <= 16'h0000;
         rd       <= 1'b0;
         wr       <= 1'b0;
         wdata    <= 9'h000;
         psw_we   <= 1'b0;
         psw_data <= 8'h00;
         psw_mask <= PSW_MASK;
      end
      else
      begin
         st       <= next_st;
         pc       <= next_pc;
         rel      <= next_rel;
         disp     <= next_disp;
         ptr_lo   <= next_ptr_lo;
         branch   <= next_branch;
         indexed  <= next_indexed;
         busy     <= next_busy;
         done     <= next_done;
         illegal  <= next_illegal;
         pc_out   <= next_pc_out;
         len      <= next_len;
         cyc      <= next_cyc;
         addr     <= next_addr;
         rd       <= next_rd;
         wr       <= next_wr;
         wdata    <= next_wdata;
         psw_we   <= next_psw_we;
         psw_data <= next_psw_data;
         psw_mask <= next_psw_mask;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign BUSY_O      = busy;
   assign DONE_O      = done;
   assign ILLEGAL_O   = illegal;
   assign PC_O        = pc_out;
   assign LEN_O       = len;
   assign CYCLES_O    = cyc;
   assign MEM_ADDR_O  = addr;
   assign MEM_RD_O    = rd;
   assign MEM_WR_O    = wr;
   assign MEM_WDATA_O = wdata;
   assign PSW_WE_O    = psw_we;
   assign PSW_MASK_O  = psw_mask;
   assign PSW_WDATA_O = psw_data;

endmodule : bdb_exec

`default_nettype wire

// ===== bdb_exec_assertions.sv
// Port-level checker for the byte decrement and branch unit.
// Sees only the unit's ports; bound to every bdb_exec instance.
`timescale 1ns/10ps
`default_nettype none
module bdb_exec_assertions
   import bdb_pkg::*;
(
   input wire logic        CLK_I,
   input wire logic        RESET_I,
   input wire logic        START_I,
   input wire logic [7:0]  OPCODE_I,
   input wire logic [7:0]  OPND1_I,
   input wire logic [7:0]  OPND2_I,
   input wire logic [7:0]  OPND3_I,
   input wire logic [15:0] PC_I,
   input wire logic [8:0]  MEM_RDATA_I,
   input wire logic        MEM_HAS_B8_I,
   input wire logic        MEM_ACK_I,
   input wire logic        BUSY_O,
   input wire logic        DONE_O,
   input wire logic        ILLEGAL_O,
   input wire logic [15:0] PC_O,
   input wire logic [2:0]  LEN_O,
   input wire logic [1:0]  CYCLES_O,
   input wire logic [15:0] MEM_ADDR_O,
   input wire logic        MEM_RD_O,
   input wire logic        MEM_WR_O,
   input wire logic [8:0]  MEM_WDATA_O,
   input wire logic        PSW_WE_O,
   input wire logic [7:0]  PSW_MASK_O,
   input wire logic [7:0]  PSW_WDATA_O
);
   logic [15:0] pc_s, next_pc_s;
   logic [7:0]  off_s, next_off_s;
   logic [8:0]  rd_v, next_rd_v, wr_v, next_wr_v;
   logic        take, known;

   // -----------------------------------------------------------
   // Operand tracking
   // -----------------------------------------------------------
   assign take  = START_I && !BUSY_O;
   assign known = (OPCODE_I inside {8'h33, 8'h34, 8'h35, 8'h36})
                  || (OPCODE_I == 8'h9A && !OPND1_I[7]);
   // The last read before a write is always the target byte
   always_comb
   begin
      next_pc_s  = take ? PC_I : pc_s;
      next_off_s = !take ? off_s : (OPCODE_I == 8'h36 ? OPND3_I : OPND2_I);
      next_wr_v  = (MEM_WR_O && MEM_ACK_I) ? MEM_WDATA_O : wr_v;
      next_rd_v  = !(MEM_RD_O && MEM_ACK_I) ? rd_v : MEM_HAS_B8_I ?
                   MEM_RDATA_I : {1'b1, MEM_RDATA_I[7:0]};
   end
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         {pc_s, off_s, rd_v, wr_v} <= '0;
      else
         {pc_s, off_s, rd_v, wr_v} <= {next_pc_s, next_off_s, next_rd_v,
                                       next_wr_v};
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   sequence s_take_op(logic [7:0] op);
      take && OPCODE_I == op;
   endsequence
   sequence s_wr_ack;
      MEM_WR_O && MEM_ACK_I;
   endsequence

   property p_long_len;
      s_take_op(8'h36) |=> LEN_O == 3'h4 && CYCLES_O == 2'h3;
   endproperty
   a_long_len: assert property (p_long_len)
      else $error("long form length or cycles wrong");
   property p_short_len;
      take && OPCODE_I inside {8'h33, 8'h34, 8'h35}
         |=> LEN_O == 3'h3 && CYCLES_O == 2'h2;
   endproperty
   a_short_len: assert property (p_short_len)
      else $error("short form length or cycles wrong");
   property p_short_addr;
      s_take_op(8'h33) |=> MEM_RD_O && MEM_ADDR_O == {8'hFE, $past(OPND1_I)};
   endproperty
   a_short_addr: assert property (p_short_addr)
      else $error("short form address page wrong");
   property p_ptr_lo;
      s_take_op(8'h9A) ##0 !OPND1_I[7]
         |=> MEM_RD_O && MEM_ADDR_O == {8'h00, $past(OPND1_I) & 8'h7E};
   endproperty
   a_ptr_lo: assert property (p_ptr_lo)
      else $error("pointer low byte address wrong");
   property p_dec;
      s_wr_ack |-> MEM_WDATA_O == rd_v - 9'h001;
   endproperty
   a_dec: assert property (p_dec)
      else $error("write data is not the decremented value");
   property p_psw;
      PSW_WE_O |-> DONE_O && PSW_MASK_O == 8'h02
         && PSW_WDATA_O == {6'h00, wr_v[8], 1'b0};
   endproperty
   a_psw: assert property (p_psw)
      else $error("status flag write wrong");
   property p_pc_br;
      DONE_O && LEN_O != 3'h2 |-> PC_O == pc_s + {13'h0, LEN_O}
         + (wr_v[7:0] == 8'h00 ? {{8{off_s[7]}}, off_s} : 16'h0000);
   endproperty
   a_pc_br: assert property (p_pc_br)
      else $error("branch target wrong");
   property p_pc_ind;
      DONE_O && LEN_O == 3'h2 |-> PC_O == pc_s + 16'h0002;
   endproperty
   a_pc_ind: assert property (p_pc_ind)
      else $error("indirect form next pc wrong");
   property p_done;
      s_wr_ack |=> DONE_O && PSW_WE_O && !BUSY_O ##1 !DONE_O;
   endproperty
   a_done: assert property (p_done)
      else $error("done pulse does not follow write");
   property p_illegal;
      take && !known |=> ILLEGAL_O && !MEM_RD_O && !DONE_O;
   endproperty
   a_illegal: assert property (p_illegal)
      else $error("unhandled opcode not refused");
endmodule : bdb_exec_assertions

bind bdb_exec bdb_exec_assertions i_chk (.*);
`default_nettype wire

// ===== bdb_mem_model.sv
// Data memory model answering the unit's read and write strobes.
// Page FExx holds 9-bit registers; every other location is 8 bits.
`timescale 1ns/10ps
`default_nettype none
module bdb_mem_model
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        slow_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [8:0]  wdata_i,
   output logic [8:0]       rdata_o,
   output logic             b8_o,
   output logic             ack_o
);
   logic [8:0] mem [0:65535];
   logic [1:0] cnt;
   logic       b8;

   assign b8 = addr_i[15:8] == 8'hFE;
   // Data toggles outside the ack cycle so a late sample is caught
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         {cnt, ack_o, b8_o, rdata_o} <= '0;
      else
      begin
         ack_o   <= 1'b0;
         rdata_o <= ~rdata_o;
         b8_o    <= ~b8_o;
         cnt     <= 2'h0;
         if ((rd_i || wr_i) && !ack_o)
         begin
            cnt <= cnt + 2'h1;
            if (cnt == (slow_i ? 2'h2 : 2'h0))
            begin
               cnt     <= 2'h0;
               ack_o   <= 1'b1;
               rdata_o <= mem[addr_i];
               b8_o    <= b8;
               if (wr_i)
                  mem[addr_i] <= b8 ? wdata_i : {1'b0, wdata_i[7:0]};
            end
         end
      end
   end
endmodule : bdb_mem_model
`default_nettype wire

// ===== byte_decrement_branch_exec_tb_top.sv
// Self-checking bench for the byte decrement and branch unit.
// Drives instruction bytes directly; the memory model answers the bus.
`timescale 1ns/10ps
`default_nettype none
module byte_decrement_branch_exec_tb_top;
   logic        clk = 0, rst = 1, start = 0, slow = 0;
   logic [7:0]  op = 0, o1 = 0, o2 = 0, o3 = 0, disp = 0, psw_m, psw_d;
   logic [15:0] pc = 0, pc_o, addr;
   logic [8:0]  rdata, wdata;
   logic [2:0]  len_o;
   logic [1:0]  cyc_o;
   logic        b8, ack, busy, done, ill, rd, wr, we;
   int          n_fail = 0, tests_run = 0;

   always #2 clk = ~clk;
   bdb_mem_model i_mem (.clk_i(clk), .rst_i(rst), .slow_i(slow), .rd_i(rd),
      .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
      .b8_o(b8), .ack_o(ack));
   bdb_exec i_dut (.CLK_I(clk), .RESET_I(rst), .START_I(start),
      .OPCODE_I(op), .OPND1_I(o1), .OPND2_I(o2), .OPND3_I(o3), .PC_I(pc),
      .DISP_I(disp), .MEM_RDATA_I(rdata), .MEM_HAS_B8_I(b8),
      .MEM_ACK_I(ack), .BUSY_O(busy), .DONE_O(done), .ILLEGAL_O(ill),
      .PC_O(pc_o), .LEN_O(len_o), .CYCLES_O(cyc_o), .MEM_ADDR_O(addr),
      .MEM_RD_O(rd), .MEM_WR_O(wr), .MEM_WDATA_O(wdata), .PSW_WE_O(we),
      .PSW_MASK_O(psw_m), .PSW_WDATA_O(psw_d));

   // -----------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic end_sim;
      $display("Checks: %0d, mismatches: %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   // A length of zero marks an instruction that must be refused
   task automatic exec(input logic [7:0] c, a1, a2, a3, d,
      input logic [15:0] p, a, input logic [8:0] v,
      input logic [15:0] epc, input logic [2:0] len);
      logic [8:0] res;
      int         n;
      res = (a[15:8] == 8'hFE ? v : {1'b1, v[7:0]}) - 9'h001;
      n = 0;
      @(posedge clk);
      #1;
      i_mem.mem[a] = v;
      {op, o1, o2, o3, disp, pc, start} = {c, a1, a2, a3, d, p, 1'b1};
      @(posedge clk);
      #1;
      start = 1'b0;
      while (done !== 1'b1 && ill !== 1'b1 && n < 60)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (len == 3'h0)
         chk(ill === 1'b1 && rd === 1'b0, "not refused");
      else
      begin
         chk(done === 1'b1 && pc_o === epc, "next pc");
         chk(len_o === len && psw_d[1] === res[8], "len/flag");
         chk(cyc_o === (len[2] ? 2'h3 : 2'h2) && we, "cycles");
         chk(i_mem.mem[a][7:0] === res[7:0], "stored byte");
      end
   endtask : exec

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task automatic t_short;
      exec(8'h34, 8'h55, 8'h04, 0, 0, 16'h1F03, 16'h0055, 9'h001,
           16'h1F0A, 3'h3);
      exec(8'h35, 8'h20, 8'h10, 0, 0, 16'h1000, 16'h0120, 9'h005,
           16'h1003, 3'h3);
      exec(8'h33, 8'h10, 8'hF0, 0, 0, 16'h2000, 16'hFE10, 9'h101,
           16'h1FF3, 3'h3);
      exec(8'h33, 8'h11, 8'hF0, 0, 0, 16'h2000, 16'hFE11, 9'h100,
           16'h2003, 3'h3);
      exec(8'h34, 8'h30, 8'h7F, 0, 0, 16'h0400, 16'h0030, 9'h000,
           16'h0403, 3'h3);
   endtask : t_short
   task automatic t_long;
      exec(8'h36, 8'h00, 8'h02, 8'h01, 0, 16'h1F03, 16'h0200, 9'h002,
           16'h1F07, 3'h4);
      exec(8'h36, 8'h00, 8'h02, 8'h01, 0, 16'h1F07, 16'h0200, 9'h001,
           16'h1F0C, 3'h4);
      exec(8'h36, 8'h80, 8'hFF, 8'h80, 0, 16'h0100, 16'hFF80, 9'h001,
           16'h0084, 3'h4);
   endtask : t_long
   task automatic t_ind;
      i_mem.mem[16'h0002] = 9'h051;
      i_mem.mem[16'h0003] = 9'h000;
      i_mem.mem[16'h007E] = 9'h034;
      i_mem.mem[16'h007F] = 9'h012;
      exec(8'h9A, 8'h02, 0, 0, 0, 16'h0500, 16'h0051, 9'h010,
           16'h0502, 3'h2);
      exec(8'h9A, 8'h7E, 0, 0, 0, 16'hFFFF, 16'h1234, 9'h000,
           16'h0001, 3'h2);
      slow = 1'b1;
      exec(8'h9A, 8'h03, 0, 0, 8'h05, 16'h0600, 16'h0056, 9'h0FF,
           16'h0602, 3'h2);
      exec(8'h9A, 8'h03, 0, 0, 8'h80, 16'h0600, 16'hFFD1, 9'h022,
           16'h0602, 3'h2);
      exec(8'h9A, 8'h03, 0, 0, 8'h7F, 16'h0600, 16'h00D0, 9'h001,
           16'h0602, 3'h2);
      slow = 1'b0;
   endtask : t_ind
   task automatic t_bad;
      exec(8'h9C, 8'h10, 0, 0, 0, 16'h0700, 16'h0010, 9'h005,
           16'h0000, 3'h0);
      exec(8'h9A, 8'h82, 0, 0, 0, 16'h0700, 16'h0011, 9'h005,
           16'h0000, 3'h0);
   endtask : t_bad
   // Reset in the middle of an instruction, then a clean one after it
   task automatic t_rst;
      @(posedge clk);
      #1;
      i_mem.mem[16'h0040] = 9'h003;
      {op, o1, o2, pc, start} = {8'h34, 8'h40, 8'h02, 16'h0800, 1'b1};
      @(posedge clk);
      #1;
      start = 1'b0;
      chk(busy === 1'b1 && rd === 1'b1, "not busy");
      rst = 1'b1;
      @(posedge clk);
      #1;
      chk({busy, done, rd, wr, we, pc_o} === '0, "reset state");
      chk(psw_m === 8'h02, "reset mask");
      rst = 1'b0;
      exec(8'h34, 8'h40, 8'h02, 0, 0, 16'h0800, 16'h0040, 9'h003,
           16'h0803, 3'h3);
   endtask : t_rst

   initial
   begin
      #20000;
      n_fail++;
      end_sim();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      t_short();
      t_long();
      t_ind();
      t_bad();
      t_rst();
      end_sim();
   end
endmodule : byte_decrement_branch_exec_tb_top
`default_nettype wire
